/* File: hw/bal_exec.sv */
/*
  Execution unit for conditional relative jumps and data loads: holds
  the working registers and the program counter, reads data memory.
  Assumes flags, instructions and memory data come from logic on clk_sys;
  memory answers combinationally in the cycle its read enable is high.
*/
`timescale 1ns/1ns
module bal_exec
  import bal_pkg::*;
#(
  parameter int PC_W = 16
) (
  input  wire logic               clk_sys,      // system clock, 125 MHz
  input  wire logic               resetn,       // async reset, active low
  input  wire logic               ce,           // clock enable, freezes all state when low
  input  wire logic               instrValid,   // decoded instruction offered
  input  wire bal_instr_t         instr,        // decoded instruction
  output      logic               instrReady,   // unit accepts an instruction
  input  wire bal_flags_t         flags,        // status register flags
  output      logic               memRdEn,      // data memory read strobe
  output      logic [ADDR_W-1:0]  memAddr,      // data memory read address
  input  wire logic [DATA_W-1:0]  memRdData,    // data memory read data
  output      logic [PC_W-1:0]    pc,           // program counter
  input  wire logic [4:0]         obsIdx,       // register to observe
  output      logic [DATA_W-1:0]  obsData       // observed register, one cycle late
);

  typedef enum logic [1:0] {
    ST_EXEC  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_FLUSH = 2'b10
  } bal_state_t;

  bal_state_t             state_ff;
  bal_state_t             nxt_state;
  logic [PC_W-1:0]        pc_ff;
  logic [PC_W-1:0]        nxt_pc;
  logic [ADDR_W-1:0]      memAddr_ff;
  logic [ADDR_W-1:0]      nxt_memAddr;
  logic [4:0]             ldDest_ff;
  logic [4:0]             nxt_ldDest;
  logic [DATA_W-1:0]      obs_ff;
  logic [DATA_W-1:0]      nxt_obs;
  logic [DATA_W-1:0]      regs_ff [REG_COUNT];
  logic [DATA_W-1:0]      nxt_regs [REG_COUNT];
  logic [PC_W-1:0]        pcSeq;
  logic [PC_W-1:0]        pcJump;
  logic [PC_W-1:0]        offsetExt;
  logic [4:0]             ptrLo;
  logic [ADDR_W-1:0]      ptrVal;
  logic [ADDR_W-1:0]      ptrInc;
  logic [ADDR_W-1:0]      ptrDec;
  logic [4:0]             pairDst;
  logic [4:0]             pairSrc;
  logic                   accept;

  // jump condition of each conditional op
  function automatic logic jumpTaken(input bal_op_t op, input bal_flags_t f);
    logic t;
    t = 1'b0;
    case (op)
      OP_JUMP_IF_CARRY_CLEAR:       t = ~f.carry;
      OP_JUMP_IF_SAME_OR_HIGHER:    t = ~f.carry;
      OP_JUMP_IF_LOWER:             t = f.carry;
      OP_JUMP_IF_NEGATIVE:          t = f.negative;
      OP_JUMP_IF_POSITIVE:          t = ~f.negative;
      OP_JUMP_IF_SIGNED_GE:         t = ~(f.negative ^ f.overflow);
      OP_JUMP_IF_SIGNED_LESS:       t = f.negative ^ f.overflow;
      OP_JUMP_IF_HALF_CARRY_SET:    t = f.halfCarry;
      OP_JUMP_IF_HALF_CARRY_CLEAR:  t = ~f.halfCarry;
      OP_JUMP_IF_TRANSFER_FLAG_SET: t = f.transfer;
      OP_JUMP_IF_IRQ_ENABLED:       t = f.irqEn;
      OP_JUMP_IF_IRQ_DISABLED:      t = ~f.irqEn;
      default:                      t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic isJump(input bal_op_t op);
    return (op >= OP_JUMP_IF_CARRY_CLEAR) && (op <= OP_JUMP_IF_IRQ_DISABLED);
  endfunction

  function automatic logic [4:0] ptrBase(input bal_psel_t sel);
    logic [4:0] b;
    b = PTR_Z_LO;
    if (sel == PSEL_X) begin
      b = PTR_X_LO;
    end else if (sel == PSEL_Y) begin
      b = PTR_Y_LO;
    end
    return b;
  endfunction

  assign instrReady = (state_ff == ST_EXEC);
  assign accept     = instrValid && instrReady;
  assign memRdEn    = (state_ff == ST_LOAD);
  assign memAddr    = memAddr_ff;
  assign pc         = pc_ff;
  assign obsData    = obs_ff;

  // offset sign-extended, sum wraps at PC_W bits
  assign offsetExt = {{(PC_W-OFFSET_W){instr.offset[OFFSET_W-1]}}, instr.offset};
  assign pcSeq     = pc_ff + PC_W'(PC_STEP);
  assign pcJump    = pcSeq + offsetExt;

  assign ptrLo   = ptrBase(instr.psel);
  assign ptrVal  = {regs_ff[ptrLo + 5'd1], regs_ff[ptrLo]};
  assign ptrInc  = ptrVal + ADDR_W'(1);
  assign ptrDec  = ptrVal - ADDR_W'(1);
  assign pairDst = {instr.rd[4:1], 1'b0};
  assign pairSrc = {instr.rr[4:1], 1'b0};

  always_comb begin
    nxt_state   = state_ff;
    nxt_pc      = pc_ff;
    nxt_memAddr = memAddr_ff;
    nxt_ldDest  = ldDest_ff;
    nxt_regs    = regs_ff;
    nxt_obs     = regs_ff[obsIdx];
    case (state_ff)
      ST_EXEC: begin
        if (accept) begin
          nxt_pc = pcSeq;
          if (isJump(instr.op)) begin
            // flags are only read, never written
            if (jumpTaken(instr.op, flags)) begin
              nxt_pc    = pcJump;
              nxt_state = ST_FLUSH;
            end
          end else begin
            case (instr.op)
              OP_REGISTER_COPY: begin
                nxt_regs[instr.rd] = regs_ff[instr.rr];
              end
              OP_REGISTER_PAIR_COPY: begin
                nxt_regs[pairDst]        = regs_ff[pairSrc];
                nxt_regs[pairDst + 5'd1] = regs_ff[pairSrc + 5'd1];
              end
              OP_IMMEDIATE_LOAD: begin
                nxt_regs[instr.rd] = instr.imm;
              end
              OP_INDIRECT_LOAD: begin
                nxt_ldDest  = instr.rd;
                nxt_state   = ST_LOAD;
                nxt_memAddr = ptrVal;
                if (instr.pmode == PMODE_POST_INC) begin
                  nxt_regs[ptrLo]        = ptrInc[7:0];
                  nxt_regs[ptrLo + 5'd1] = ptrInc[15:8];
                end else if (instr.pmode == PMODE_PRE_DEC) begin
                  nxt_memAddr            = ptrDec;
                  nxt_regs[ptrLo]        = ptrDec[7:0];
                  nxt_regs[ptrLo + 5'd1] = ptrDec[15:8];
                end
              end
              OP_DISPLACED_LOAD: begin
                nxt_ldDest  = instr.rd;
                nxt_state   = ST_LOAD;
                nxt_memAddr = ptrVal + {{(ADDR_W-DISP_W){1'b0}}, instr.disp};
              end
              OP_DIRECT_MEMORY_LOAD: begin
                nxt_ldDest  = instr.rd;
                nxt_state   = ST_LOAD;
                nxt_memAddr = instr.addr;
                nxt_pc      = pc_ff + PC_W'(DIRECT_STEP);
              end
              default: begin
                nxt_state = ST_EXEC;
              end
            endcase
          end
        end
      end
      ST_LOAD: begin
        nxt_regs[ldDest_ff] = memRdData;
        nxt_state           = ST_EXEC;
      end
      ST_FLUSH: begin
        nxt_state = ST_EXEC;
      end
      default: begin
        nxt_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= ST_EXEC;
      pc_ff      <= '0;
      memAddr_ff <= '0;
      ldDest_ff  <= '0;
      obs_ff     <= REG_RESET;
    end else if (ce) begin
      state_ff   <= nxt_state;
      pc_ff      <= nxt_pc;
      memAddr_ff <= nxt_memAddr;
      ldDest_ff  <= nxt_ldDest;
      obs_ff     <= nxt_obs;
    end
  end

  // working registers, one flop bank each
  for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        regs_ff[g] <= REG_RESET;
      end else if (ce) begin
        regs_ff[g] <= nxt_regs[g];
      end
    end
  end

endmodule // bal_exec

/* File: pkg/bal_pkg.sv */
/*
  Shared types and constants for the branch and load execution unit:
  operation codes, pointer selections, flag and instruction carriers.
  Assumes a front end that hands over already decoded instructions.
*/
package bal_pkg;

  localparam int REG_COUNT   = 32;
  localparam int REG_IDX_W   = 5;
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 16;
  localparam int OFFSET_W    = 7;
  localparam int DISP_W      = 6;

  // low register index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam int         PC_STEP       = 1;
  localparam int         DIRECT_STEP   = 2;
  localparam int         CYC_BR_NOT    = 1;
  localparam int         CYC_BR_TAKEN  = 2;
  localparam int         CYC_COPY      = 1;
  localparam int         CYC_LOAD      = 2;

  typedef enum logic [4:0] {
    OP_NOP                        = 5'h00,
    OP_JUMP_IF_CARRY_CLEAR        = 5'h01,
    OP_JUMP_IF_SAME_OR_HIGHER     = 5'h02,
    OP_JUMP_IF_LOWER              = 5'h03,
    OP_JUMP_IF_NEGATIVE           = 5'h04,
    OP_JUMP_IF_POSITIVE           = 5'h05,
    OP_JUMP_IF_SIGNED_GE          = 5'h06,
    OP_JUMP_IF_SIGNED_LESS        = 5'h07,
    OP_JUMP_IF_HALF_CARRY_SET     = 5'h08,
    OP_JUMP_IF_HALF_CARRY_CLEAR   = 5'h09,
    OP_JUMP_IF_TRANSFER_FLAG_SET  = 5'h0a,
    OP_JUMP_IF_IRQ_ENABLED        = 5'h0b,
    OP_JUMP_IF_IRQ_DISABLED       = 5'h0c,
    OP_REGISTER_COPY              = 5'h0d,
    OP_REGISTER_PAIR_COPY         = 5'h0e,
    OP_IMMEDIATE_LOAD             = 5'h0f,
    OP_INDIRECT_LOAD              = 5'h10,
    OP_DISPLACED_LOAD             = 5'h11,
    OP_DIRECT_MEMORY_LOAD         = 5'h12
  } bal_op_t;

  typedef enum logic [1:0] {
    PSEL_X = 2'h0,
    PSEL_Y = 2'h1,
    PSEL_Z = 2'h2
  } bal_psel_t;

  typedef enum logic [1:0] {
    PMODE_PLAIN    = 2'h0,
    PMODE_POST_INC = 2'h1,
    PMODE_PRE_DEC  = 2'h2
  } bal_pmode_t;

  // status flags, same bit order as the status register
  typedef struct packed {
    logic irqEn;
    logic transfer;
    logic halfCarry;
    logic sign;
    logic overflow;
    logic negative;
    logic zero;
    logic carry;
  } bal_flags_t;

  typedef struct packed {
    bal_op_t              op;
    logic [4:0]           rd;
    logic [4:0]           rr;
    logic [7:0]           imm;
    logic [6:0]           offset;
    logic [5:0]           disp;
    bal_psel_t            psel;
    bal_pmode_t           pmode;
    logic [15:0]          addr;
  } bal_instr_t;

endpackage

/* File: test/bal_exec_asserts.sv */
/* port checker for the execution unit: jump, copy and load timing
   assumes bind onto bal_exec and ce held high through multi-cycle ops */
`timescale 1ns/1ns
module bal_exec_asserts
  import bal_pkg::*;
#(
  parameter int PC_W = 16
) (
  input wire logic              clk_sys,    // clock
  input wire logic              resetn,     // async reset, low
  input wire logic              ce,         // clock enable
  input wire logic              instrValid, // offer
  input wire bal_instr_t        instr,      // instruction
  input wire logic              instrReady, // accept
  input wire bal_flags_t        flags,      // status flags
  input wire logic              memRdEn,    // read strobe
  input wire logic [ADDR_W-1:0] memAddr,    // read address
  input wire logic [PC_W-1:0]   pc          // program counter
);
  logic            acc;
  logic            isBr;
  logic            take;
  logic [PC_W-1:0] tgt;
  assign acc = instrValid && instrReady && ce;
  assign isBr = instr.op inside {[OP_JUMP_IF_CARRY_CLEAR:OP_JUMP_IF_IRQ_DISABLED]};
  assign tgt = pc + PC_W'(1) + PC_W'(signed'(instr.offset));
  always_comb begin
    case (instr.op)
      OP_JUMP_IF_CARRY_CLEAR, OP_JUMP_IF_SAME_OR_HIGHER: take = !flags.carry;
      OP_JUMP_IF_LOWER:            take = flags.carry;
      OP_JUMP_IF_NEGATIVE:         take = flags.negative;
      OP_JUMP_IF_POSITIVE:         take = !flags.negative;
      OP_JUMP_IF_SIGNED_GE:        take = !(flags.negative ^ flags.overflow);
      OP_JUMP_IF_SIGNED_LESS:      take = flags.negative ^ flags.overflow;
      OP_JUMP_IF_HALF_CARRY_SET:   take = flags.halfCarry;
      OP_JUMP_IF_HALF_CARRY_CLEAR: take = !flags.halfCarry;
      OP_JUMP_IF_TRANSFER_FLAG_SET: take = flags.transfer;
      OP_JUMP_IF_IRQ_ENABLED:      take = flags.irqEn;
      OP_JUMP_IF_IRQ_DISABLED:     take = !flags.irqEn;
      default:                     take = 1'b0;
    endcase
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_gap;
    !instrReady ##1 instrReady;
  endsequence
  sequence s_read;
    memRdEn && !instrReady ##1 !memRdEn && instrReady;
  endsequence
  a_jump_taken: assert property (
    acc && isBr && take |=> pc == $past(tgt) ##0 s_gap) else $error("taken jump wrong");
  a_jump_skip: assert property (
    acc && isBr && !take |=> pc == $past(pc) + PC_W'(1) && instrReady) else $error("skipped jump wrong");
  a_copy_single: assert property (
    acc && instr.op inside {OP_REGISTER_COPY, OP_REGISTER_PAIR_COPY, OP_IMMEDIATE_LOAD}
    |=> instrReady && !memRdEn && pc == $past(pc) + PC_W'(1)) else $error("copy timing wrong");
  a_load_read: assert property (
    acc && instr.op inside {[OP_INDIRECT_LOAD:OP_DIRECT_MEMORY_LOAD]} |=> s_read) else $error("load read wrong");
  a_direct_addr: assert property (
    acc && instr.op == OP_DIRECT_MEMORY_LOAD |=> memAddr == $past(instr.addr) && pc == $past(pc) + PC_W'(2))
    else $error("direct address wrong");
  a_read_pc_hold: assert property (memRdEn |=> $stable(pc)) else $error("pc moved in load");
  a_ready_back: assert property (!instrReady && ce |=> instrReady) else $error("ready stuck low");
  a_read_excl: assert property (memRdEn |-> !instrReady) else $error("read while ready");
endmodule // bal_exec_asserts

bind bal_exec bal_exec_asserts #(.PC_W(PC_W)) u_chk (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .instrValid(instrValid), .instr(instr), .instrReady(instrReady), .flags(flags), .memRdEn(memRdEn),
  .memAddr(memAddr), .pc(pc));

/* File: test/bal_mem_model.sv */
/* data memory model: content derived from the address
   assumes single-cycle read strobes on clk_sys */
`timescale 1ns/1ns
module bal_mem_model
  import bal_pkg::*;
(
  input  wire logic              clk_sys,  // clock
  input  wire logic              memRdEn,  // read strobe
  input  wire logic [ADDR_W-1:0] memAddr,  // read address
  output      logic [DATA_W-1:0] memRdData // read data
);
  logic [DATA_W-1:0] lastQ;
  // outside a read the bus toggles, never holds old data
  assign memRdData = memRdEn ? (memAddr[7:0] ^ memAddr[15:8] ^ 8'h5a) : ~lastQ;
  always_ff @(posedge clk_sys) lastQ <= memRdData;
endmodule // bal_mem_model

/* File: test/tb.sv */
/* self-checking bench for the execution unit
   assumes the memory model and the bound checker compiled alongside */
`timescale 1ns/1ns
module tb;
  import bal_pkg::*;
  logic clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, instrValid = 1'b0, instrReady, memRdEn, rdyA;
  bal_instr_t instr = '0, ins;
  bal_flags_t flags = '0;
  logic [ADDR_W-1:0] memAddr;
  logic [DATA_W-1:0] memRdData, obsData, v;
  logic [4:0]        obsIdx = 5'h00;
  logic [15:0]       pc, expPc = 16'h0000;
  int                failures = 0, totalChecks = 0, cyc;
  always #4 clk_sys = ~clk_sys;
  bal_exec dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .instrValid(instrValid), .instr(instr),
    .instrReady(instrReady), .flags(flags), .memRdEn(memRdEn), .memAddr(memAddr), .memRdData(memRdData),
    .pc(pc), .obsIdx(obsIdx), .obsData(obsData));
  bal_mem_model mem (.clk_sys(clk_sys), .memRdEn(memRdEn), .memAddr(memAddr), .memRdData(memRdData));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    totalChecks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic op(input bal_op_t o, input logic [4:0] d, input logic [4:0] r, input logic [7:0] k);
    ins = '0;
    ins.op = o;
    ins.rd = d;
    ins.rr = r;
    ins.imm = k;
  endtask
  task automatic go();
    int n;
    n = 0;
    instrValid = 1'b1;
    instr = ins;
    @(posedge clk_sys);
    #1;
    rdyA = instrReady;
    if (rdyA !== 1'b1) instrValid = 1'b0;
    while (instrReady !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cyc = n + 1;
  endtask
  task automatic rd(input logic [4:0] i);
    if (instrValid) instrValid = 1'b0;
    obsIdx = i;
    @(posedge clk_sys);
    #1;
    v = obsData;
  endtask
  task automatic li(input logic [4:0] d, input logic [7:0] k);
    op(OP_IMMEDIATE_LOAD, d, 5'h00, k);
    go();
    expPc++;
  endtask
  task automatic t_branch();
    logic [11:0] tab [3] = '{12'h933, 12'h6ac, 12'h94b};
    logic [7:0]  fl [3] = '{8'h00, 8'hff, 8'h04};
    logic [6:0]  off;
    for (int s = 0; s < 3; s++) begin
      flags = fl[s];
      for (int k = 0; k < 12; k++) begin
        off = k[0] ? 7'h05 : 7'h7d;
        op(bal_op_t'(k + 1), 5'h00, 5'h00, 8'h00);
        ins.offset = off;
        go();
        expPc = expPc + 16'h0001 + (tab[s][k] ? {{9{off[6]}}, off} : 16'h0000);
        chk(pc, expPc);
        chk(16'(cyc), tab[s][k] ? 16'h0002 : 16'h0001);
      end
    end
  endtask
  task automatic t_copy();
    li(5'h10, 8'ha5);
    li(5'h11, 8'h3c);
    op(OP_REGISTER_COPY, 5'h01, 5'h10, 8'h00);
    go();
    op(OP_REGISTER_PAIR_COPY, 5'h03, 5'h11, 8'h00);
    go();
    expPc = expPc + 16'h0002;
    chk(pc, expPc);
    rd(5'h01);
    chk(16'(v), 16'h00a5);
    rd(5'h02);
    chk(16'(v), 16'h00a5);
    rd(5'h03);
    chk(16'(v), 16'h003c);
  endtask
  task automatic ld(input bal_op_t o, input logic [4:0] d, input bal_psel_t p, input bal_pmode_t m,
                    input logic [5:0] q, input logic [15:0] a, input logic [15:0] ea);
    op(o, d, 5'h00, 8'h00);
    ins.psel = p;
    ins.pmode = m;
    ins.disp = q;
    ins.addr = a;
    go();
    expPc = expPc + ((o == OP_DIRECT_MEMORY_LOAD) ? 16'h0002 : 16'h0001);
    chk(pc, expPc);
    chk(16'(cyc), 16'h0002);
    rd(d);
    chk(16'(v), 16'(ea[7:0] ^ ea[15:8] ^ 8'h5a));
  endtask
  task automatic t_load();
    li(5'h1a, 8'h20);
    li(5'h1b, 8'h01);
    li(5'h1c, 8'h00);
    li(5'h1d, 8'h02);
    li(5'h1e, 8'h00);
    li(5'h1f, 8'h03);
    ld(OP_INDIRECT_LOAD, 5'h04, PSEL_X, PMODE_PLAIN, 6'h00, 16'h0000, 16'h0120);
    ld(OP_INDIRECT_LOAD, 5'h05, PSEL_X, PMODE_POST_INC, 6'h00, 16'h0000, 16'h0120);
    rd(5'h1a);
    chk(16'(v), 16'h0021);
    ld(OP_INDIRECT_LOAD, 5'h06, PSEL_Y, PMODE_PRE_DEC, 6'h00, 16'h0000, 16'h01ff);
    rd(5'h1d);
    chk(16'(v), 16'h0001);
    ld(OP_DISPLACED_LOAD, 5'h07, PSEL_Z, PMODE_PLAIN, 6'h3f, 16'h0000, 16'h033f);
    rd(5'h1e);
    chk(16'(v), 16'h0000);
    ld(OP_DIRECT_MEMORY_LOAD, 5'h08, PSEL_X, PMODE_PLAIN, 6'h00, 16'h1234, 16'h1234);
  endtask
  task automatic t_freeze();
    ce = 1'b0;
    op(OP_IMMEDIATE_LOAD, 5'h09, 5'h00, 8'hff);
    instrValid = 1'b1;
    instr = ins;
    repeat (3) @(posedge clk_sys);
    #1;
    instrValid = 1'b0;
    ce = 1'b1;
    chk(pc, expPc);
    rd(5'h09);
    chk(16'(v), 16'h0000);
  endtask
  task automatic final_report();
    if (failures == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk(pc, 16'h0000);
    t_branch();
    t_copy();
    t_load();
    t_freeze();
    final_report();
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule // tb
